/* design/shr_pkg.sv */
// Package: register map, field positions, reset values and timing for the sequencer
package shr_pkg;
    // Byte register addresses
    localparam logic [7:0] SHR_ADDR_SYSTEM_CONTROL_REG = 8'h10;
    localparam logic [7:0] SHR_ADDR_SYS_STAT = 8'h11;
    localparam logic [7:0] SHR_ADDR_RUN = 8'h21;
    localparam logic [7:0] SHR_ADDR_START = 8'h22;
    localparam logic [7:0] SHR_ADDR_STOP = 8'h23;
    localparam logic [7:0] SHR_ADDR_STAT = 8'h24;
    localparam logic [7:0] SHR_ADDR_TEMP = 8'h30;
    localparam logic [7:0] SHR_ADDR_HUM = 8'h33;
    // Field positions
    localparam int SHR_BIT_TEMP = 0;
    localparam int SHR_BIT_HUM = 1;
    localparam int SHR_BIT_LOW_POWER = 0;
    localparam int SHR_BIT_SW_RESET = 7;
    localparam int SHR_VALID_POS = 16;
    localparam int SHR_CRC_LSB = 17;
    // Reset values
    localparam logic SHR_LOW_POWER_RST = 1'b1;
    localparam logic [1:0] SHR_RUN_RST = 2'h0;
    // CRC-7 constants
    localparam int SHR_CRC_W = 7;
    localparam int SHR_PAYLOAD_W = 17;
    localparam logic [7:0] SHR_CRC_POLY = 8'h89;
    localparam logic [6:0] SHR_CRC_SEED = 7'h7F;
    // Timing, cycle counts at 10 MHz
    localparam int SHR_CLK_NS = 100;
    localparam int SHR_BOOT_NS = 1000;
    localparam int SHR_BOOT_CYC = (SHR_BOOT_NS + SHR_CLK_NS - 1) / SHR_CLK_NS;
    localparam int SHR_CONV_NS = 2000;
    localparam int SHR_CONV_CYC = (SHR_CONV_NS + SHR_CLK_NS - 1) / SHR_CLK_NS;

    typedef enum logic [1:0] {
        SHR_ST_STANDBY = 2'b00,
        SHR_ST_BOOT = 2'b01,
        SHR_ST_MEASURE = 2'b10,
        SHR_ST_ACTIVE = 2'b11
    } shr_state_e;

    // Register-port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } shr_req_s;

    // Converter result pair
    typedef struct packed {
        logic [15:0] temp;
        logic [15:0] hum;
    } shr_data_s;
endpackage

/* design/shr_crc7.sv */
// CRC-7 over a 17-bit payload, fully combinational
`timescale 1ns/100ps
module shr_crc7
    import shr_pkg::*;
(
    // Payload in, checksum out
    input wire logic [SHR_PAYLOAD_W-1:0] payload,
    output logic [SHR_CRC_W-1:0] crc
);
    localparam int W = SHR_PAYLOAD_W + SHR_CRC_W;

    logic [W-1:0] stage [0:SHR_PAYLOAD_W];

    // RULE_11: seed appended below
    assign stage[0] = {payload, SHR_CRC_SEED};

    genvar i;
    generate
        for (i = 0; i < SHR_PAYLOAD_W; i++) begin : g_div
            localparam int TOP = W - 1 - i;
            wire [W-1:0] pol_w = W'({SHR_CRC_POLY, {(W-8){1'b0}}} >> i);
            // RULE_11: divide MSB downward
            assign stage[i+1] = stage[i][TOP] ? (stage[i] ^ pol_w) : stage[i];
        end
    endgenerate

    // RULE_10: remainder is checksum
    assign crc = stage[SHR_PAYLOAD_W][SHR_CRC_W-1:0];
endmodule

/* design/shr_sequencer.sv */
// Measurement sequencer, result registers and byte register port
`timescale 1ns/100ps
// Function
// RULE_01: Single-shot ignores the stop bit
// RULE_02: Start clears valid and boots
// RULE_03: Awake flag, then measuring bit; from standby the code raises both on the same edge when boot ends
// RULE_04: Single-shot end: valid, clear, standby
// RULE_05: Host keeps stop low for continuous
// RULE_06: Continuous keeps measuring, valid stays set
// RULE_07: Stop finishes current, updates, standby
// RULE_08: Control writes apply between measurements
// RULE_09: Word: data, valid, checksum layout
// RULE_10: CRC-7, poly 0x89, seed 0x7F
// RULE_11: Seed appended, divide from MSB
// RULE_12: Valid clears at start, sets done
// RULE_13: First byte read snapshots whole word
// RULE_14: Temperature word little-endian at 0x30
// RULE_15: Temperature unsigned kelvin, 1/64 LSB
// RULE_16: Humidity unsigned percent, 1/512 LSB
// RULE_17: Humidity word right after temperature
// RULE_18: Writing 0x03 to 0x22 starts both
// RULE_19: Host may read data bytes only
// RULE_20: Repeated start/stop act once per step
// RULE_21: Start bit per sensor, 01/10/11
// RULE_22: Idle step goes standby unless disabled
// RULE_23: Combined step stays awake until both
module shr_sequencer
    import shr_pkg::*;
#(
    parameter int BOOT_CYC = SHR_BOOT_CYC,
    parameter int CONV_CYC = SHR_CONV_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Register port from the serial slave
    input wire shr_req_s req,
    output logic [7:0] rdata,
    output logic wr_ack,
    // Converter results, raw fixed-point
    input wire shr_data_s conv_data,
    // Status outputs
    output logic system_awake_flag,
    output logic [1:0] measuring
);
    logic rst_meta_q, rst_sync_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    wire rst_n = rst_sync_q;

    shr_state_e state_q, state_d;
    logic [15:0] cnt_q, cnt_d;
    logic low_power_q;
    logic [1:0] run_q, start_q, stop_q, step_q, step_d;
    logic [1:0] valid_q;
    logic [15:0] tdata_q, hdata_q;
    logic [23:0] buf_q [0:1];
    logic [7:0] rdata_q;
    logic sw_reset_q;

    // Register decode
    wire wr_ctrl = req.wr && req.addr == SHR_ADDR_SYSTEM_CONTROL_REG;
    wire wr_run = req.wr && req.addr == SHR_ADDR_RUN;
    wire wr_start = req.wr && req.addr == SHR_ADDR_START;
    wire wr_stop = req.wr && req.addr == SHR_ADDR_STOP;
    wire wr_ok = wr_ctrl | wr_run | wr_start | wr_stop;
    wire busy = state_q == SHR_ST_BOOT || state_q == SHR_ST_MEASURE;
    wire cnt_done = cnt_q == 16'h0000;
    wire meas_done = state_q == SHR_ST_MEASURE && cnt_done;

    // Next step: continuous sensors without stop, plus fresh starts
    wire [1:0] cont_again = step_q & run_q & ~stop_q;
    // RULE_20: pending start acts once
    wire [1:0] next_step = cont_again | start_q;

    // Measurement words with checksum
    logic [6:0] crc_tv, crc_hv;
    shr_crc7 u_crc_tv (.payload({valid_q[SHR_BIT_TEMP], tdata_q}), .crc(crc_tv));
    shr_crc7 u_crc_hv (.payload({valid_q[SHR_BIT_HUM], hdata_q}), .crc(crc_hv));
    // RULE_09: checksum, valid, data
    wire [23:0] word_t = {crc_tv, valid_q[SHR_BIT_TEMP], tdata_q};
    wire [23:0] word_h = {crc_hv, valid_q[SHR_BIT_HUM], hdata_q};

    // Sequencer
    always_comb begin
        state_d = state_q;
        cnt_d = (cnt_q == 16'h0000) ? cnt_q : cnt_q - 16'h0001;
        step_d = step_q;
        case (state_q)
            SHR_ST_STANDBY, SHR_ST_ACTIVE: begin
                if (start_q != 2'b00) begin
                    step_d = start_q;
                    // RULE_02: start boots from standby
                    state_d = (state_q == SHR_ST_STANDBY) ? SHR_ST_BOOT : SHR_ST_MEASURE;
                    cnt_d = (state_q == SHR_ST_STANDBY) ? 16'(BOOT_CYC - 1) : 16'(CONV_CYC - 1);
                end else if (state_q == SHR_ST_ACTIVE && low_power_q) begin
                    state_d = SHR_ST_STANDBY;
                end else if (state_q == SHR_ST_STANDBY && !low_power_q) begin
                    state_d = SHR_ST_ACTIVE;
                end
            end
            SHR_ST_BOOT: begin
                // RULE_03: boot end raises awake and measuring on the same edge
                if (cnt_done) begin
                    state_d = SHR_ST_MEASURE;
                    cnt_d = 16'(CONV_CYC - 1);
                end
            end
            SHR_ST_MEASURE: begin
                // RULE_23: both sensors end together
                if (cnt_done) begin
                    if (next_step != 2'b00) begin
                        // RULE_06: continuous restarts at once
                        step_d = next_step;
                        cnt_d = 16'(CONV_CYC - 1);
                    end else begin
                        // RULE_22: standby unless low power off
                        step_d = 2'b00;
                        state_d = low_power_q ? SHR_ST_STANDBY : SHR_ST_ACTIVE;
                    end
                end
            end
            default: state_d = SHR_ST_STANDBY;
        endcase
    end

    wire step_begin = (state_q == SHR_ST_STANDBY || state_q == SHR_ST_ACTIVE) && start_q != 2'b00;
    wire [1:0] started = step_begin ? start_q : (meas_done ? next_step & ~step_q : 2'b00);
    // Start bits still pending once the sequencer has taken its share
    wire [1:0] start_pend = (meas_done || step_begin) ? 2'b00 : start_q;
    // Sensors of the running step; a start for them must not queue a rerun
    wire [1:0] in_step = busy ? step_q : 2'b00;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= SHR_ST_STANDBY;
            cnt_q <= 16'h0000;
            step_q <= 2'b00;
        end else if (sw_reset_q) begin
            state_q <= SHR_ST_STANDBY;
            cnt_q <= 16'h0000;
            step_q <= 2'b00;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            step_q <= step_d;
        end
    end

    // Control registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_power_q <= SHR_LOW_POWER_RST;
            run_q <= SHR_RUN_RST;
            start_q <= 2'b00;
            stop_q <= 2'b00;
            sw_reset_q <= 1'b0;
        end else if (sw_reset_q) begin
            low_power_q <= SHR_LOW_POWER_RST;
            run_q <= SHR_RUN_RST;
            start_q <= 2'b00;
            stop_q <= 2'b00;
            sw_reset_q <= 1'b0;
        end else begin
            sw_reset_q <= wr_ctrl && req.wdata[SHR_BIT_SW_RESET];
            if (wr_ctrl) begin
                low_power_q <= req.wdata[SHR_BIT_LOW_POWER];
            end
            // RULE_08: run mode latched between steps
            if (wr_run && !busy) begin
                run_q <= req.wdata[1:0];
            end
            if (meas_done) begin
                // RULE_04: clear start, and stop of the sensors in this step
                // RULE_07: stop ends after this one
                start_q <= 2'b00;
                stop_q <= stop_q & ~step_q;
            end else if (step_begin) begin
                start_q <= 2'b00;
            end
            // RULE_21: one start bit per sensor
            // RULE_18: 0x03 starts both
            // RULE_20: restart of a running sensor dropped
            if (wr_start) begin
                start_q <= start_pend | (req.wdata[1:0] & ~in_step);
            end
            // RULE_01: stop ignored in single-shot
            if (wr_stop) begin
                stop_q <= (meas_done ? stop_q & ~step_q : stop_q) | (req.wdata[1:0] & run_q);
            end
        end
    end

    // Results and valid flags
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            valid_q <= 2'b00;
            tdata_q <= 16'h0000;
            hdata_q <= 16'h0000;
        end else begin
            // RULE_15: raw kelvin, 1/64 LSB
            if (meas_done && step_q[SHR_BIT_TEMP]) begin
                tdata_q <= conv_data.temp;
            end
            // RULE_16: raw percent, 1/512 LSB
            if (meas_done && step_q[SHR_BIT_HUM]) begin
                hdata_q <= conv_data.hum;
            end
            // RULE_12: set at done, clear at start
            valid_q <= (valid_q | (meas_done ? step_q : 2'b00)) & ~started;
        end
    end

    // RULE_13: first byte snapshots word
    wire snap_t = req.rd && req.addr == SHR_ADDR_TEMP;
    wire snap_h = req.rd && req.addr == SHR_ADDR_HUM;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            buf_q[0] <= 24'h000000;
            buf_q[1] <= 24'h000000;
        end else begin
            if (snap_t) begin
                buf_q[0] <= word_t;
            end
            if (snap_h) begin
                buf_q[1] <= word_h;
            end
        end
    end

    // Read mux; reserved addresses read zero
    logic [7:0] rd_mux;
    always_comb begin
        case (req.addr)
            SHR_ADDR_SYSTEM_CONTROL_REG: rd_mux = {7'h00, low_power_q};
            SHR_ADDR_SYS_STAT: rd_mux = {7'h00, system_awake_flag};
            SHR_ADDR_RUN: rd_mux = {6'h00, run_q};
            SHR_ADDR_STAT: rd_mux = {6'h00, measuring};
            // RULE_14: little-endian bytes
            SHR_ADDR_TEMP: rd_mux = word_t[7:0];
            SHR_ADDR_TEMP + 8'h01: rd_mux = buf_q[0][15:8];
            SHR_ADDR_TEMP + 8'h02: rd_mux = buf_q[0][23:16];
            // RULE_17: humidity follows temperature
            SHR_ADDR_HUM: rd_mux = word_h[7:0];
            SHR_ADDR_HUM + 8'h01: rd_mux = buf_q[1][15:8];
            SHR_ADDR_HUM + 8'h02: rd_mux = buf_q[1][23:16];
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (req.rd) begin
            rdata_q <= rd_mux;
        end
    end

    assign rdata = rdata_q;
    assign wr_ack = wr_ok;
    // RULE_03: awake outside standby and boot
    assign system_awake_flag = state_q == SHR_ST_MEASURE || state_q == SHR_ST_ACTIVE;
    assign measuring = (state_q == SHR_ST_MEASURE) ? step_q : 2'b00;
endmodule

/* verification/shr_sequencer_sva.sv */
// Port checker for the measurement sequencer
`timescale 1ns/100ps
module shr_sequencer_sva
    import shr_pkg::*;
#(
    parameter int BOOT_CYC = SHR_BOOT_CYC,
    parameter int CONV_CYC = SHR_CONV_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Register port
    input wire shr_req_s req,
    input wire logic [7:0] rdata,
    input wire logic wr_ack,
    // Status
    input wire logic system_awake_flag,
    input wire logic [1:0] measuring
);
    // Start to first measuring cycle, with slack for pending and boot entry
    localparam int BW = BOOT_CYC + 6;
    wire logic wr_ok = req.addr inside {SHR_ADDR_SYSTEM_CONTROL_REG, SHR_ADDR_RUN, SHR_ADDR_START,
        SHR_ADDR_STOP};
    wire logic start_idle = req.wr && req.addr == SHR_ADDR_START && req.wdata[1:0] != 2'b00
        && !system_awake_flag;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    property p_wr_ack; wr_ack == (req.wr && wr_ok); endproperty
    a_wr_ack: assert property (p_wr_ack) else $error("write ack mismatch");
    property p_meas_awake; measuring != 2'b00 |-> system_awake_flag; endproperty
    a_meas_awake: assert property (p_meas_awake) else $error("measuring while asleep");
    property p_sleep; $fell(system_awake_flag) |-> measuring == 2'b00; endproperty
    a_sleep: assert property (p_sleep) else $error("standby during measurement");
    property p_boot;
        start_idle |=> (measuring == 2'b00)[*2] ##[1:BW] measuring != 2'b00;
    endproperty
    a_boot: assert property (p_boot) else $error("start did not boot and measure");
    property p_conv; $rose(measuring[0]) |-> measuring[0][*5]; endproperty
    a_conv: assert property (p_conv) else $error("measurement cut short");
    property p_stat_rd;
        req.rd && req.addr == SHR_ADDR_STAT |=> rdata == {6'h00, $past(measuring)};
    endproperty
    a_stat_rd: assert property (p_stat_rd) else $error("sensor status read wrong");
    property p_sys_rd;
        req.rd && req.addr == SHR_ADDR_SYS_STAT |=> rdata == {7'h00, $past(system_awake_flag)};
    endproperty
    a_sys_rd: assert property (p_sys_rd) else $error("system status read wrong");
    property p_rd_hold; !req.rd |=> $stable(rdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");

    c_both: cover property (measuring == 2'b11);
    c_sleep: cover property ($fell(system_awake_flag));
    c_hum_rd: cover property (req.rd && req.addr == SHR_ADDR_HUM);
endmodule

bind shr_sequencer shr_sequencer_sva #(.BOOT_CYC(BOOT_CYC), .CONV_CYC(CONV_CYC)) u_sva (
    .sys_clk(sys_clk), .rstn(rstn), .req(req), .rdata(rdata), .wr_ack(wr_ack),
    .system_awake_flag(system_awake_flag), .measuring(measuring));

/* verification/shr_host.sv */
// Host model: byte register master of the sequencer
`timescale 1ns/100ps
module shr_host
    import shr_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Register port
    output shr_req_s req,
    input wire logic [7:0] rdata,
    input wire logic wr_ack
);
    initial req = '{1'b0, 1'b0, 8'h00, 8'h00};
    // Released lines show inverted values so stale data cannot pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ack);
        @(posedge sys_clk);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge sys_clk);
        ack = wr_ack;
        req <= '{1'b0, 1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge sys_clk);
        req <= '{1'b0, 1'b0, ~a, 8'hFF};
        @(posedge sys_clk);
        d = rdata;
    endtask
endmodule

/* verification/sensor_measure_sequencer_readout_bench.sv */
// Self-checking bench for the measurement sequencer
`timescale 1ns/100ps
module sensor_measure_sequencer_readout_bench
    import shr_pkg::*;
;
    localparam int BOOT = 4;
    localparam int CONV = 20;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    shr_data_s conv_data = 32'h0000_0000;
    shr_req_s req;
    logic [7:0] rdata, b;
    logic wr_ack, ack, system_awake_flag;
    logic [1:0] measuring;
    logic [23:0] w, e;
    integer seed = 32'h1c1550dc;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int md [2] = '{0, 0};
    int mv [2] = '{0, 0};
    int codes [$] = '{3, 1, 2};
    logic [7:0] wa [7] = '{8'h10, 8'h21, 8'h22, 8'h23, 8'h24, 8'h30, 8'h40};

    shr_sequencer #(.BOOT_CYC(BOOT), .CONV_CYC(CONV)) u_shr_sequencer (.sys_clk(sys_clk),
        .rstn(rstn), .req(req), .rdata(rdata), .wr_ack(wr_ack), .conv_data(conv_data),
        .system_awake_flag(system_awake_flag), .measuring(measuring));
    shr_host u_host (.sys_clk(sys_clk), .req(req), .rdata(rdata), .wr_ack(wr_ack));

    initial forever #50 sys_clk = ~sys_clk;

    function automatic int crc7(input int val);
        int pol, bm;
        pol = 32'h89 << 16;
        bm = 32'h10000 << 7;
        val = (val << 7) | 32'h7F;
        while (bm & (32'h1FFFF << 7)) begin
            if (bm & val) val ^= pol;
            bm >>= 1;
            pol >>= 1;
        end
        return val & 32'h7F;
    endfunction
    function automatic logic [23:0] word(input int i);
        int p;
        p = (mv[i] << 16) | md[i];
        return 24'((crc7(p) << 17) | p);
    endfunction
    task automatic chk(input string n, input logic [23:0] x, input logic [23:0] g);
        comparisons++;
        if (g !== x) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic rd_word(input logic [7:0] a, output logic [23:0] v);
        logic [7:0] b0, b1, b2;
        u_host.rd(a, b0);
        u_host.rd(a + 8'h01, b1);
        u_host.rd(a + 8'h02, b2);
        v = {b2, b1, b0};
    endtask
    // Waits: 1 measuring, 0 not measuring, 2 asleep
    task automatic wt(input int k);
        int n;
        for (n = 0; n < 300; n++) begin
            @(negedge sys_clk);
            if (k == 1 && measuring !== 2'b00 || k == 0 && measuring === 2'b00
                || k == 2 && system_awake_flag === 1'b0) break;
        end
        chk("wait", 24'h0, 24'(n / 300));
    endtask
    task automatic shot(input int c, input bit known);
        @(posedge sys_clk);
        conv_data <= $random(seed);
        u_host.wr(SHR_ADDR_STOP, 8'h03, ack);
        u_host.wr(SHR_ADDR_START, 8'(c), ack);
        for (int i = 0; i < 2; i++) if (c[i]) mv[i] = 0;
        wt(1);
        rd_word(SHR_ADDR_TEMP, w);
        if (known) chk("temp busy", word(0), w);
        u_host.rd(SHR_ADDR_STAT, b);
        chk("sens stat", 24'(c), 24'(b));
        u_host.rd(SHR_ADDR_SYS_STAT, b);
        chk("sys stat", 24'h1, 24'(b));
        wt(0);
        repeat (3) @(negedge sys_clk);
        chk("awake", 24'h0, 24'(system_awake_flag));
        for (int i = 0; i < 2; i++) if (c[i]) md[i] = i ? conv_data.hum : conv_data.temp;
        for (int i = 0; i < 2; i++) if (c[i]) mv[i] = 1;
        rd_word(SHR_ADDR_TEMP, w);
        chk("temp word", word(0), w);
        rd_word(SHR_ADDR_HUM, w);
        chk("hum word", word(1), w);
        $display("test single shot %0d done", c);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            summarize();
        end
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        // Writes of reset-like values only, so nothing starts here
        for (int i = 0; i < 7; i++) begin
            u_host.wr(wa[i], {7'h00, i == 0}, ack);
            chk("write ack", 24'(i < 4), 24'(ack));
        end
        u_host.rd(8'h40, b);
        chk("reserved read", 24'h0, 24'(b));
        $display("test register port done");
        foreach (codes[i]) shot(codes[i], i > 0);
        @(posedge sys_clk);
        conv_data <= $random(seed);
        u_host.wr(SHR_ADDR_RUN, 8'h01, ack);
        u_host.wr(SHR_ADDR_STOP, 8'h00, ack);
        u_host.wr(SHR_ADDR_START, 8'h01, ack);
        wt(1);
        repeat (2 * CONV + 10) @(negedge sys_clk);
        md[0] = conv_data.temp;
        mv[0] = 1;
        e = word(0);
        rd_word(SHR_ADDR_TEMP, w);
        chk("cont word", e, w);
        u_host.rd(SHR_ADDR_TEMP, b);
        @(posedge sys_clk);
        conv_data <= $random(seed);
        repeat (2 * CONV + 10) @(negedge sys_clk);
        u_host.rd(SHR_ADDR_TEMP + 8'h01, w[15:8]);
        u_host.rd(SHR_ADDR_TEMP + 8'h02, w[23:16]);
        chk("snapshot", e[23:8], w[23:8]);
        chk("cont awake", 24'h1, 24'(system_awake_flag));
        @(posedge sys_clk);
        conv_data <= $random(seed);
        u_host.wr(SHR_ADDR_STOP, 8'h01, ack);
        wt(2);
        md[0] = conv_data.temp;
        rd_word(SHR_ADDR_TEMP, w);
        chk("stop word", word(0), w);
        u_host.wr(SHR_ADDR_RUN, 8'h00, ack);
        $display("test continuous done");
        u_host.wr(SHR_ADDR_SYSTEM_CONTROL_REG, 8'h00, ack);
        u_host.wr(SHR_ADDR_START, 8'h02, ack);
        wt(1);
        wt(0);
        repeat (20) @(negedge sys_clk);
        chk("stay awake", 24'h1, 24'(system_awake_flag));
        u_host.wr(SHR_ADDR_SYSTEM_CONTROL_REG, 8'h01, ack);
        wt(2);
        $display("test low power done");
        u_host.wr(SHR_ADDR_RUN, 8'h03, ack);
        u_host.rd(SHR_ADDR_RUN, b);
        chk("run readback", 24'h3, 24'(b));
        u_host.wr(SHR_ADDR_SYSTEM_CONTROL_REG, 8'h80, ack);
        u_host.rd(SHR_ADDR_RUN, b);
        chk("reset run", 24'h0, 24'(b));
        u_host.rd(SHR_ADDR_SYSTEM_CONTROL_REG, b);
        chk("reset ctrl", 24'h1, 24'(b));
        rd_word(SHR_ADDR_TEMP, w);
        chk("kept word", word(0), w);
        $display("test soft reset done");
        summarize();
    end
endmodule
